// [ect_pkg.sv]
// ect_pkg.sv
// constants and types shared by the compare timer files
// assumes a 32-bit avalon-mm slave, one aligned word per register
package ect_pkg;

	// register word indices, byte address is index times four
	localparam logic [2:0] ECT_IDX_COUNT = 3'h0;
	localparam logic [2:0] ECT_IDX_CMP_A = 3'h1;
	localparam logic [2:0] ECT_IDX_CMP_B = 3'h2;
	localparam logic [2:0] ECT_IDX_CTRL  = 3'h3;
	localparam logic [2:0] ECT_IDX_STAT  = 3'h4;
	localparam logic [2:0] ECT_IDX_TRIG  = 3'h5;

	// values after reset, and the counter maximum
	localparam logic [7:0] ECT_COUNT_RST = 8'h00;
	localparam logic [7:0] ECT_CMP_RST   = 8'hFF;
	localparam logic [7:0] ECT_CTRL_RST  = 8'h00;
	localparam logic [2:0] ECT_FLAG_RST  = 3'h0;
	localparam logic [3:0] ECT_OSEL_RST  = 4'h0;
	localparam logic [1:0] ECT_EDGE_RST  = 2'h0;
	localparam logic       ECT_BIT_RST   = 1'b0;
	localparam logic       ECT_RUN_RST   = 1'b1;
	localparam logic [7:0] ECT_COUNT_MAX = 8'hFF;

	// bits that always read as one
	localparam logic [7:0] ECT_STAT_ONES = 8'h10;
	localparam logic [7:0] ECT_TRIG_ONES = 8'hE2;

	// field positions
	localparam int ECT_CTRL_IE_LSB   = 5;
	localparam int ECT_CTRL_CLR_LSB  = 3;
	localparam int ECT_CTRL_CKS_LSB  = 0;
	localparam int ECT_STAT_FLG_LSB  = 5;
	localparam int ECT_STAT_OSB_LSB  = 2;
	localparam int ECT_STAT_OSA_LSB  = 0;
	localparam int ECT_TRIG_EDGE_LSB = 3;
	localparam int ECT_TRIG_STOP_BIT = 2;
	localparam int ECT_TRIG_TAP_BIT  = 0;

	// flag order inside the three-bit flag vector
	localparam int ECT_FLG_WRAP = 0;
	localparam int ECT_FLG_A    = 1;
	localparam int ECT_FLG_B    = 2;

	// prescaler width, top tap divides by 128
	localparam int ECT_DIV_W = 7;

	typedef enum logic [1:0] {
		ECT_CLR_NONE = 2'h0,
		ECT_CLR_A    = 2'h1,
		ECT_CLR_B    = 2'h2,
		ECT_CLR_PIN  = 2'h3
	} ect_clr_t;

	typedef enum logic [1:0] {
		ECT_ACT_KEEP = 2'h0,
		ECT_ACT_LOW  = 2'h1,
		ECT_ACT_HIGH = 2'h2,
		ECT_ACT_TOG  = 2'h3
	} ect_act_t;

	typedef enum logic [1:0] {
		ECT_EDGE_OFF  = 2'h0,
		ECT_EDGE_RISE = 2'h1,
		ECT_EDGE_FALL = 2'h2,
		ECT_EDGE_BOTH = 2'h3
	} ect_edge_t;

	typedef enum logic [1:0] {
		ECT_BUS_IDLE = 2'b01,
		ECT_BUS_ACK  = 2'b10
	} ect_bus_t;

endpackage : ect_pkg

// [ect_edge_sync.sv]
// ect_edge_sync.sv
// two-stage synchroniser with rise and fall pulse detection
// assumes one clock; pulses last one cycle per pin edge
module ect_edge_sync (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic arst_n_in,
	// pin and edges
	input  wire logic pin_in,
	output logic      rise_out,
	output logic      fall_out
);

	logic s1_ff;
	logic s2_ff;
	logic s3_ff;

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
		end else begin
			s1_ff <= pin_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	assign rise_out = s2_ff & ~s3_ff;
	assign fall_out = ~s2_ff & s3_ff;

endmodule // ect_edge_sync

// [ect_prescale.sv]
// ect_prescale.sv
// free-running divider, pulse on falling edge of the chosen tap
// assumes tap_sel_in is a bit index of the divider, tap_en_in low means none
module ect_prescale #(
	parameter int unsigned DIV_W = 7
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             arst_n_in,
	// tap choice and tick
	input  wire logic [2:0]       tap_sel_in,
	input  wire logic             tap_en_in,
	output logic                  tick_out
);

	logic [DIV_W-1:0] div_ff;
	logic             tap_prev_ff;
	logic             tap_now;

	// a tap switch from high to low also counts as a falling edge
	assign tap_now  = tap_en_in & div_ff[tap_sel_in];
	assign tick_out = tap_prev_ff & ~tap_now;

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			div_ff      <= '0;
			tap_prev_ff <= 1'b0;
		end else begin
			div_ff      <= div_ff + 1'b1;
			tap_prev_ff <= tap_now;
		end
	end

endmodule // ect_prescale

// [ect_timer.sv]
// ect_timer.sv
// eight-bit compare timer with an avalon-mm register slave
// assumes timer pins sampled on clk_in (250 MHz) and a polite master
//
// What this block does
// - counter readable, writable, resets to zero
// - internal codes count on prescaler tap falls
// - external codes count pin rise, fall, both
// - wrap from max to zero sets wrap flag
// - equal compare sets match flag a, b
// - compare write cycle suppresses that match
// - compare registers reset to all ones
// - enables gate flag requests onto outputs
// - clear select: none, match a, b, pin
// - count stop halts after selected clear
// - trigger pin edge starts counting
// - flag cleared by read one, write zero
// - match b drives keep, low, high, toggle
// - match a drives same codes, independently
// - waveform pin low after reset
// - trigger reserved bits read one, ignore writes
// - trigger edge field: off, rise, fall, both
// - stopped counter resumes on trigger edge
// - coincident actions: toggle, then high, then low
// - clear beats simultaneous counter write
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
module ect_timer
	import ect_pkg::*;
#(
	parameter int unsigned DIV_W = ECT_DIV_W
) (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        arst_n_in,
	// avalon-mm slave
	input  wire logic [4:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out,
	// timer pins
	input  wire logic        ext_clock_pin_in,
	input  wire logic        ext_clear_pin_in,
	input  wire logic        trigger_pin_in,
	output logic             waveform_out_pin_out,
	// interrupt requests
	output logic             irq_match_b_out,
	output logic             irq_match_a_out,
	output logic             irq_wrap_out
);

	// registers
	logic [7:0] count_reg_ff;
	logic [7:0] compare_a_reg_ff;
	logic [7:0] compare_b_reg_ff;
	logic [7:0] clock_clear_irq_ctrl_ff;
	logic [2:0] flag_ff;
	logic [2:0] armed_ff;
	logic [3:0] out_sel_ff;
	logic [1:0] trigger_edge_ff;
	logic       count_stop_enable_ff;
	logic       tap_pair_select_ff;
	logic       running_ff;
	logic       waveform_ff;
	logic [2:0] irq_ff;

	// bus state
	ect_bus_t    state_ff;
	ect_bus_t    nxt_state;
	logic        wait_ff;
	logic [31:0] rdata_ff;
	logic [7:0]  rd_byte;
	logic [2:0]  idx;
	logic        ack;
	logic        wr_ok;
	logic [7:0]  wdata;
	logic        wr_cnt;
	logic        wr_cmpa;
	logic        wr_cmpb;
	logic        wr_ctrl;
	logic        wr_stat;
	logic        wr_trig;
	logic        rd_stat;

	// timer core
	logic [2:0]  cks;
	ect_clr_t    clr_sel;
	logic [2:0]  tap_sel;
	logic        tap_en;
	logic        int_tick;
	logic        ck_rise;
	logic        ck_fall;
	logic        cl_rise;
	logic        tg_rise;
	logic        tg_fall;
	logic        tick;
	logic        inc;
	logic        match_a;
	logic        match_b;
	logic        clr_evt;
	logic        wrap_evt;
	logic        trig_hit;
	logic [2:0]  evt;
	logic [2:0]  nxt_flag;

	function automatic logic edge_hit(input ect_edge_t sel,
		input logic r, input logic f);
		case (sel)
			ECT_EDGE_OFF:  edge_hit = 1'b0;
			ECT_EDGE_RISE: edge_hit = r;
			ECT_EDGE_FALL: edge_hit = f;
			ECT_EDGE_BOTH: edge_hit = r | f;
			default:       edge_hit = 1'b0;
		endcase
	endfunction

	function automatic logic act_is(input ect_act_t a, input logic m,
		input ect_act_t want);
		act_is = m & (a == want);
	endfunction

	// pin synchronisers
	ect_edge_sync u_ck_sync (
		.clk_in    (clk_in),
		.arst_n_in (arst_n_in),
		.pin_in    (ext_clock_pin_in),
		.rise_out  (ck_rise),
		.fall_out  (ck_fall)
	);

	ect_edge_sync u_cl_sync (
		.clk_in    (clk_in),
		.arst_n_in (arst_n_in),
		.pin_in    (ext_clear_pin_in),
		.rise_out  (cl_rise),
		.fall_out  ()
	);

	ect_edge_sync u_tg_sync (
		.clk_in    (clk_in),
		.arst_n_in (arst_n_in),
		.pin_in    (trigger_pin_in),
		.rise_out  (tg_rise),
		.fall_out  (tg_fall)
	);

	// prescaler taps, lowest pair is divide by 4 and 8
	assign cks     = clock_clear_irq_ctrl_ff[ECT_CTRL_CKS_LSB +: 3];
	assign tap_en  = ~cks[2] & (cks[1:0] != 2'h0);
	assign tap_sel = {cks[1:0], tap_pair_select_ff} - 3'h1;

	ect_prescale #(
		.DIV_W (DIV_W)
	) u_prescale (
		.clk_in     (clk_in),
		.arst_n_in  (arst_n_in),
		.tap_sel_in (tap_sel),
		.tap_en_in  (tap_en),
		.tick_out   (int_tick)
	);

	// count source, match and clear decisions
	assign clr_sel = ect_clr_t'(clock_clear_irq_ctrl_ff[ECT_CTRL_CLR_LSB +: 2]);
	assign tick    = cks[2] ? edge_hit(ect_edge_t'(cks[1:0]), ck_rise, ck_fall)
		: (tap_en & int_tick);
	assign inc     = tick & running_ff;
	assign match_a = inc & (count_reg_ff == compare_a_reg_ff) & ~wr_cmpa;
	assign match_b = inc & (count_reg_ff == compare_b_reg_ff) & ~wr_cmpb;
	assign clr_evt = ((clr_sel == ECT_CLR_A) & match_a)
		| ((clr_sel == ECT_CLR_B) & match_b)
		| ((clr_sel == ECT_CLR_PIN) & cl_rise);
	assign wrap_evt = inc & (count_reg_ff == ECT_COUNT_MAX)
		& ~clr_evt & ~wr_cnt;
	assign trig_hit = edge_hit(ect_edge_t'(trigger_edge_ff), tg_rise,
		tg_fall);
	assign evt = {match_b, match_a, wrap_evt};

	// bus decode, a write takes effect only in the acknowledge cycle
	assign idx     = avs_address_in[4:2];
	assign ack     = (state_ff == ECT_BUS_ACK);
	assign wr_ok   = ack & avs_write_in & avs_byteenable_in[0];
	assign wdata   = avs_writedata_in[7:0];
	assign wr_cnt  = wr_ok & (idx == ECT_IDX_COUNT);
	assign wr_cmpa = wr_ok & (idx == ECT_IDX_CMP_A);
	assign wr_cmpb = wr_ok & (idx == ECT_IDX_CMP_B);
	assign wr_ctrl = wr_ok & (idx == ECT_IDX_CTRL);
	assign wr_stat = wr_ok & (idx == ECT_IDX_STAT);
	assign wr_trig = wr_ok & (idx == ECT_IDX_TRIG);
	assign rd_stat = ack & avs_read_in & (idx == ECT_IDX_STAT);

	always_comb begin
		case (idx)
			ECT_IDX_COUNT: rd_byte = count_reg_ff;
			ECT_IDX_CMP_A: rd_byte = compare_a_reg_ff;
			ECT_IDX_CMP_B: rd_byte = compare_b_reg_ff;
			ECT_IDX_CTRL:  rd_byte = clock_clear_irq_ctrl_ff;
			ECT_IDX_STAT:  rd_byte = ECT_STAT_ONES
				| {flag_ff, 1'b0, out_sel_ff};
			ECT_IDX_TRIG:  rd_byte = ECT_TRIG_ONES
				| {3'h0, trigger_edge_ff, count_stop_enable_ff, 1'b0,
				tap_pair_select_ff};
			default:       rd_byte = 8'h00;
		endcase
	end

	always_comb begin
		case (state_ff)
			ECT_BUS_IDLE: nxt_state = (avs_read_in | avs_write_in)
				? ECT_BUS_ACK : ECT_BUS_IDLE;
			ECT_BUS_ACK:  nxt_state = ECT_BUS_IDLE;
			default:      nxt_state = ECT_BUS_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_ff <= ECT_BUS_IDLE;
			wait_ff  <= 1'b1;
			rdata_ff <= 32'h0000_0000;
		end else begin
			state_ff <= nxt_state;
			wait_ff  <= (nxt_state != ECT_BUS_ACK);
			if (state_ff == ECT_BUS_IDLE && avs_read_in)
				rdata_ff <= {24'h00_0000, rd_byte};
		end
	end

	// counter: clear beats write, write beats increment
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			count_reg_ff <= ECT_COUNT_RST;
		end else if (clr_evt) begin
			count_reg_ff <= ECT_COUNT_RST;
		end else if (wr_cnt) begin
			count_reg_ff <= wdata;
		end else if (inc) begin
			count_reg_ff <= count_reg_ff + 8'h01;
		end
	end

	// compare and control registers
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			compare_a_reg_ff        <= ECT_CMP_RST;
			compare_b_reg_ff        <= ECT_CMP_RST;
			clock_clear_irq_ctrl_ff <= ECT_CTRL_RST;
			out_sel_ff              <= ECT_OSEL_RST;
			trigger_edge_ff         <= ECT_EDGE_RST;
			count_stop_enable_ff    <= ECT_BIT_RST;
			tap_pair_select_ff      <= ECT_BIT_RST;
		end else begin
			if (wr_cmpa)
				compare_a_reg_ff <= wdata;
			if (wr_cmpb)
				compare_b_reg_ff <= wdata;
			if (wr_ctrl)
				clock_clear_irq_ctrl_ff <= wdata;
			if (wr_stat)
				out_sel_ff <= wdata[3:0];
			if (wr_trig) begin
				trigger_edge_ff      <= wdata[ECT_TRIG_EDGE_LSB +: 2];
				count_stop_enable_ff <= wdata[ECT_TRIG_STOP_BIT];
				tap_pair_select_ff   <= wdata[ECT_TRIG_TAP_BIT];
			end
		end
	end

	// flags: read as one arms the clear, a new event wins over clear
	always_comb begin
		nxt_flag = flag_ff;
		if (wr_stat)
			nxt_flag = flag_ff & ~(armed_ff
				& ~wdata[ECT_STAT_FLG_LSB +: 3]);
		nxt_flag = nxt_flag | evt;
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			flag_ff  <= ECT_FLAG_RST;
			armed_ff <= ECT_FLAG_RST;
		end else begin
			flag_ff <= nxt_flag;
			if (rd_stat)
				armed_ff <= rdata_ff[ECT_STAT_FLG_LSB +: 3];
			else if (wr_stat)
				armed_ff <= ECT_FLAG_RST;
		end
	end

	// count stop and trigger restart
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			running_ff <= ECT_RUN_RST;
		end else if (!count_stop_enable_ff) begin
			running_ff <= 1'b1;
		end else if (clr_evt) begin
			running_ff <= 1'b0;
		end else if (trig_hit) begin
			running_ff <= 1'b1;
		end
	end

	// waveform pin, toggle over high over low
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			waveform_ff <= ECT_BIT_RST;
		end else if (act_is(ect_act_t'(out_sel_ff[1:0]), match_a, ECT_ACT_TOG)
			| act_is(ect_act_t'(out_sel_ff[3:2]), match_b, ECT_ACT_TOG)) begin
			waveform_ff <= ~waveform_ff;
		end else if (act_is(ect_act_t'(out_sel_ff[1:0]), match_a, ECT_ACT_HIGH)
			| act_is(ect_act_t'(out_sel_ff[3:2]), match_b, ECT_ACT_HIGH)) begin
			waveform_ff <= 1'b1;
		end else if (act_is(ect_act_t'(out_sel_ff[1:0]), match_a, ECT_ACT_LOW)
			| act_is(ect_act_t'(out_sel_ff[3:2]), match_b, ECT_ACT_LOW)) begin
			waveform_ff <= 1'b0;
		end
	end

	// request lines follow flag and enable
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			irq_ff <= ECT_FLAG_RST;
		else
			irq_ff <= flag_ff
				& clock_clear_irq_ctrl_ff[ECT_CTRL_IE_LSB +: 3];
	end

	assign avs_readdata_out     = rdata_ff;
	assign avs_waitrequest_out  = wait_ff;
	assign waveform_out_pin_out = waveform_ff;
	assign irq_match_b_out      = irq_ff[ECT_FLG_B];
	assign irq_match_a_out      = irq_ff[ECT_FLG_A];
	assign irq_wrap_out         = irq_ff[ECT_FLG_WRAP];

	// checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	sequence s_stat_write_zero_a;
		wr_stat & armed_ff[ECT_FLG_A] & ~wdata[ECT_STAT_FLG_LSB + ECT_FLG_A];
	endsequence

	sequence s_no_new_a;
		~match_a;
	endsequence

	property p_count_write;
		wr_cnt & ~clr_evt |=> count_reg_ff == $past(wdata);
	endproperty
	a_count_write: assert property (p_count_write)
		else $error("counter write not taken");

	property p_wrap_flag;
		wrap_evt |=> flag_ff[ECT_FLG_WRAP] ##1 irq_wrap_out
			|| !clock_clear_irq_ctrl_ff[ECT_CTRL_IE_LSB];
	endproperty
	a_wrap_flag: assert property (p_wrap_flag)
		else $error("wrap flag or request missing");

	property p_match_a_flag;
		match_a |=> flag_ff[ECT_FLG_A];
	endproperty
	a_match_a_flag: assert property (p_match_a_flag)
		else $error("match a flag not set");

	property p_cmp_write_masks;
		wr_cmpa & inc & (count_reg_ff == compare_a_reg_ff)
			& ~flag_ff[ECT_FLG_A] |=> !flag_ff[ECT_FLG_A];
	endproperty
	a_cmp_write_masks: assert property (p_cmp_write_masks)
		else $error("match a during compare write");

	property p_clear_zero;
		clr_evt |=> count_reg_ff == ECT_COUNT_RST;
	endproperty
	a_clear_zero: assert property (p_clear_zero)
		else $error("counter not cleared");

	property p_stop_after_clear;
		count_stop_enable_ff & clr_evt & ~wr_trig
			|=> !running_ff ##1 (count_reg_ff == ECT_COUNT_RST || wr_cnt
			|| $past(wr_cnt) || running_ff);
	endproperty
	a_stop_after_clear: assert property (p_stop_after_clear)
		else $error("counter did not halt after clear");

	property p_restart;
		count_stop_enable_ff & !running_ff & trig_hit & ~clr_evt & ~wr_trig
			|=> running_ff;
	endproperty
	a_restart: assert property (p_restart)
		else $error("trigger edge did not restart count");

	property p_flag_clear;
		s_stat_write_zero_a ##0 s_no_new_a |=> !flag_ff[ECT_FLG_A];
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("armed flag a not cleared");

	property p_write_one_ignored;
		flag_ff[ECT_FLG_A] & wr_stat & wdata[ECT_STAT_FLG_LSB + ECT_FLG_A]
			|=> flag_ff[ECT_FLG_A];
	endproperty
	a_write_one_ignored: assert property (p_write_one_ignored)
		else $error("flag a lost on write of one");

	property p_trig_ones;
		ack & avs_read_in & (idx == ECT_IDX_TRIG)
			|-> avs_readdata_out[7:5] == 3'h7;
	endproperty
	a_trig_ones: assert property (p_trig_ones)
		else $error("trigger reserved bits not one");

	property p_toggle_first;
		match_a & match_b
			& ((out_sel_ff[1:0] == 2'h3) || (out_sel_ff[3:2] == 2'h3))
			|=> waveform_out_pin_out != $past(waveform_out_pin_out);
	endproperty
	a_toggle_first: assert property (p_toggle_first)
		else $error("toggle did not win");

	property p_b_low;
		match_b & (out_sel_ff[3:2] == 2'h1) & ~(match_a & out_sel_ff[1])
			|=> !waveform_out_pin_out;
	endproperty
	a_b_low: assert property (p_b_low)
		else $error("match b did not drive low");

	property p_irq_gate;
		irq_match_a_out |-> $past(flag_ff[ECT_FLG_A])
			&& $past(clock_clear_irq_ctrl_ff[ECT_CTRL_IE_LSB + ECT_FLG_A]);
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("request a without flag and enable");

endmodule // ect_timer

// [ect_pin_model.sv]
// ect_pin_model.sv
// far side of the timer: drives clock, clear and trigger pins, loads output
// assumes one request pulse at a time, raised only while busy_out is low
module ect_pin_model (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       arst_n_in,
	// requests: bit 0 clock pin, bit 1 clear pin, bit 2 trigger pin
	input  wire logic [2:0] pulse_req_in,
	input  wire logic       slow_in,
	input  wire logic       wave_in,
	// pins and status
	output logic            ext_clock_out,
	output logic            ext_clear_out,
	output logic            trigger_out,
	output logic            busy_out,
	output logic [7:0]      wave_rises_out
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [2:0] sel_ff;
	logic [3:0] ph_ff;
	logic       wave_ff;
	logic [3:0] half;

	assign half = slow_in ? 4'h7 : 4'h3;
	// pins idle low, each level held several clocks
	assign {trigger_out, ext_clear_out, ext_clock_out} =
		(busy_out && ph_ff < half) ? sel_ff : 3'h0;

	// one high phase then one low phase per request
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			busy_out <= 1'b0;
			sel_ff   <= 3'h0;
			ph_ff    <= 4'h0;
		end else if (!busy_out) begin
			busy_out <= pulse_req_in != 3'h0;
			sel_ff   <= pulse_req_in;
			ph_ff    <= 4'h0;
		end else begin
			ph_ff    <= ph_ff + 4'h1;
			busy_out <= ph_ff != (2 * half - 1);
		end
	end

	// counts rising edges of the waveform output
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wave_ff        <= 1'b0;
			wave_rises_out <= 8'h00;
		end else begin
			wave_ff <= wave_in;
			if (wave_in && !wave_ff) begin
				wave_rises_out <= wave_rises_out + 8'h01;
			end
		end
	end
endmodule // ect_pin_model

// [ect_timer_tb.sv]
// ect_timer_tb.sv
// self-checking bench for the compare timer and its register slave
// assumes the pin model drives the timer inputs, one clock of 250 MHz
module ect_timer_tb
	import ect_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic       wr;
		logic [2:0] idx;
		logic [7:0] wd;
		logic [7:0] exp;
	} ect_row_t;

	localparam ect_row_t ROWS [0:15] = '{
		'{1'b0, ECT_IDX_COUNT, 8'h00, ECT_COUNT_RST},
		'{1'b0, ECT_IDX_CMP_A, 8'h00, ECT_CMP_RST},
		'{1'b0, ECT_IDX_CMP_B, 8'h00, ECT_CMP_RST},
		'{1'b0, ECT_IDX_CTRL, 8'h00, ECT_CTRL_RST},
		'{1'b0, ECT_IDX_STAT, 8'h00, 8'h10},
		'{1'b0, ECT_IDX_TRIG, 8'h00, 8'hE2},
		'{1'b0, 3'h6, 8'h00, 8'h00},
		'{1'b1, ECT_IDX_COUNT, 8'h5A, 8'h5A},
		'{1'b1, ECT_IDX_CMP_A, 8'h3C, 8'h3C},
		'{1'b1, ECT_IDX_CMP_B, 8'hC3, 8'hC3},
		'{1'b1, ECT_IDX_TRIG, 8'h1D, 8'hFF},
		'{1'b1, ECT_IDX_TRIG, 8'h00, 8'hE2},
		'{1'b1, ECT_IDX_STAT, 8'hEF, 8'h1F},
		'{1'b1, ECT_IDX_STAT, 8'h00, 8'h10},
		'{1'b1, 3'h7, 8'h55, 8'h00},
		'{1'b1, ECT_IDX_CTRL, 8'hF8, 8'hF8}};
	// output select code beside the waveform level it must give
	localparam logic [8:0] ACTS [0:4] = '{{8'h06, 1'b1}, {8'h00, 1'b1},
		{8'h05, 1'b0}, {8'h00, 1'b0}, {8'h09, 1'b1}};

	logic        clk_in;
	logic        arst_n_in;
	logic [4:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        ext_clock_pin;
	logic        ext_clear_pin;
	logic        trigger_pin;
	logic        waveform_out_pin;
	logic        irq_b;
	logic        irq_a;
	logic        irq_wrap;
	logic [2:0]  pulse_req;
	logic        slow;
	logic        busy;
	logic [7:0]  wave_rises;
	logic [7:0]  v;
	logic [7:0]  a;
	logic [7:0]  b;
	int          n_fail;
	int          n_compared;

	ect_timer DUT (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.avs_address_in(avs_address), .avs_read_in(avs_read),
		.avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
		.avs_byteenable_in(avs_byteenable), .avs_readdata_out(avs_readdata),
		.avs_waitrequest_out(avs_waitrequest),
		.ext_clock_pin_in(ext_clock_pin), .ext_clear_pin_in(ext_clear_pin),
		.trigger_pin_in(trigger_pin), .waveform_out_pin_out(waveform_out_pin),
		.irq_match_b_out(irq_b), .irq_match_a_out(irq_a),
		.irq_wrap_out(irq_wrap));

	ect_pin_model pins (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.pulse_req_in(pulse_req), .slow_in(slow), .wave_in(waveform_out_pin),
		.ext_clock_out(ext_clock_pin), .ext_clear_out(ext_clear_pin),
		.trigger_out(trigger_pin), .busy_out(busy), .wave_rises_out(wave_rises));

	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cmp1(input string nm, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %b seen %b", nm, e, g);
		end
	endtask

	// one avalon access, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [2:0] i, input logic [7:0] d,
		input logic [3:0] be, output logic [7:0] q);
		int k;
		@(posedge clk_in);
		avs_address    <= {i, 2'b00};
		avs_write      <= w;
		avs_read       <= !w;
		avs_writedata  <= {24'h000000, d};
		avs_byteenable <= be;
		k = 0;
		do begin
			@(negedge clk_in);
			k++;
		end while (avs_waitrequest !== 1'b0);
		cmp1("wait states", 1'b1, k == 2);
		@(posedge clk_in);
		q = avs_readdata[7:0];
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [2:0] i, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, i, d, 4'hF, q);
	endtask

	task automatic rd(input logic [2:0] i, output logic [7:0] q);
		bus(1'b0, i, 8'h00, 4'hF, q);
	endtask

	task automatic pulse(input logic [2:0] m);
		pulse_req <= m;
		@(posedge clk_in);
		pulse_req <= 3'h0;
		do begin
			@(negedge clk_in);
		end while (busy === 1'b1);
		cyc(4);
	endtask

	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		cyc(60000);
		n_fail++;
		complete_run();
	end

	initial begin
		n_fail = 0;
		n_compared = 0;
		arst_n_in = 1'b0;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'hF;
		pulse_req = 3'h0;
		slow = 1'b0;
		cyc(2);
		arst_n_in <= 1'b1;
		cmp1("wave after reset", 1'b0, waveform_out_pin);
		foreach (ROWS[j]) begin
			if (ROWS[j].wr) begin
				wr(ROWS[j].idx, ROWS[j].wd);
			end
			rd(ROWS[j].idx, v);
			cmp8("register", ROWS[j].exp, v);
		end
		// two tap periods between reads give two ticks
		for (int c = 0; c < 5; c++) begin
			for (int t = 0; t < 2; t++) begin
				wr(ECT_IDX_TRIG, 8'(t));
				wr(ECT_IDX_CTRL, 8'(c));
				rd(ECT_IDX_COUNT, a);
				cyc((c >= 1 && c <= 3) ? (8 << (2 * c + t - 2)) - 3 : 13);
				rd(ECT_IDX_COUNT, b);
				cmp8("tap count", (c >= 1 && c <= 3) ? 8'h02 : 8'h00, b - a);
			end
		end
		for (int c = 5; c < 8; c++) begin
			wr(ECT_IDX_CTRL, 8'(c));
			wr(ECT_IDX_COUNT, 8'h00);
			slow <= (c == 6);
			repeat (3) pulse(3'b001);
			rd(ECT_IDX_COUNT, v);
			cmp8("ext count", (c == 7) ? 8'h06 : 8'h03, v);
		end
		slow <= 1'b0;
		rd(ECT_IDX_STAT, v);
		wr(ECT_IDX_STAT, 8'h00);
		wr(ECT_IDX_CTRL, 8'h20);
		wr(ECT_IDX_COUNT, 8'hFE);
		wr(ECT_IDX_CTRL, 8'h21);
		cyc(20);
		wr(ECT_IDX_CTRL, 8'h20);
		cyc(2);
		cmp1("wrap irq", 1'b1, irq_wrap);
		wr(ECT_IDX_CTRL, 8'h00);
		cyc(2);
		cmp1("wrap irq masked", 1'b0, irq_wrap);
		wr(ECT_IDX_CTRL, 8'h20);
		wr(ECT_IDX_STAT, 8'h00);
		rd(ECT_IDX_STAT, v);
		cmp8("flags kept", 8'h30, v);
		wr(ECT_IDX_STAT, 8'h00);
		rd(ECT_IDX_STAT, v);
		cmp8("flags cleared", 8'h10, v);
		cyc(2);
		cmp1("wrap irq cleared", 1'b0, irq_wrap);
		// match a clears and toggles the waveform
		wr(ECT_IDX_CMP_A, 8'h05);
		wr(ECT_IDX_STAT, 8'h03);
		wr(ECT_IDX_COUNT, 8'h00);
		wr(ECT_IDX_CTRL, 8'h49);
		a = wave_rises;
		for (int j = 0; j < 6; j++) begin
			rd(ECT_IDX_COUNT, v);
			cmp1("count under a", 1'b1, v <= 8'h05);
		end
		cyc(200);
		cmp1("irq a", 1'b1, irq_a);
		cmp1("toggles a", 1'b1, 8'(wave_rises - a) >= 8'h02);
		rd(ECT_IDX_STAT, v);
		wr(ECT_IDX_STAT, 8'h43);
		rd(ECT_IDX_STAT, v);
		cmp1("flag a kept", 1'b1, v[6]);
		wr(ECT_IDX_CMP_B, 8'h03);
		wr(ECT_IDX_CTRL, 8'h91);
		wr(ECT_IDX_COUNT, 8'h00);
		bus(1'b1, ECT_IDX_CMP_B, 8'h11, 4'h0, v);
		rd(ECT_IDX_CMP_B, v);
		cmp8("masked write", 8'h03, v);
		for (int j = 0; j < 6; j++) begin
			rd(ECT_IDX_COUNT, v);
			cmp1("count under b", 1'b1, v <= 8'h03);
		end
		cyc(40);
		cmp1("irq b", 1'b1, irq_b);
		// both matches at once: level actions
		wr(ECT_IDX_CMP_A, 8'h03);
		foreach (ACTS[j]) begin
			wr(ECT_IDX_STAT, ACTS[j][8:1]);
			cyc(60);
			cmp1("wave level", ACTS[j][0], waveform_out_pin);
		end
		wr(ECT_IDX_STAT, 8'h0D);
		a = wave_rises;
		cyc(100);
		cmp1("toggle wins", 1'b1, wave_rises != a);
		// stop on clear, restart on rise, fall and both trigger edge codes, none on off
		wr(ECT_IDX_CMP_A, 8'h05);
		wr(ECT_IDX_CTRL, 8'h09);
		wr(ECT_IDX_TRIG, 8'h04);
		cyc(40);
		for (int e = 0; e < 4; e++) begin
			wr(ECT_IDX_TRIG, 8'(e * 8 + 4));
			rd(ECT_IDX_STAT, v);
			wr(ECT_IDX_STAT, 8'h00);
			cyc(40);
			rd(ECT_IDX_STAT, v);
			cmp1("stopped", 1'b0, v[6]);
			pulse(3'b100);
			cyc(40);
			rd(ECT_IDX_STAT, v);
			cmp1("restarted", e != 0, v[6]);
		end
		wr(ECT_IDX_TRIG, 8'h00);
		wr(ECT_IDX_CTRL, 8'h19);
		wr(ECT_IDX_COUNT, 8'h80);
		pulse(3'b010);
		rd(ECT_IDX_COUNT, v);
		cmp1("pin clear", 1'b1, v < 8'h10);
		// second reset in mid-run
		arst_n_in <= 1'b0;
		cyc(2);
		arst_n_in <= 1'b1;
		cmp1("wave after reset", 1'b0, waveform_out_pin);
		rd(ECT_IDX_COUNT, v);
		cmp8("count after reset", ECT_COUNT_RST, v);
		rd(ECT_IDX_CMP_A, v);
		cmp8("compare after reset", ECT_CMP_RST, v);
		complete_run();
	end
endmodule // ect_timer_tb
